// file: logic/pbc_basic_control.sv
// Management frame slave holding the basic control register and its control outputs
`timescale 1ns/1ns
`include "pbc_regs.svh"

module pbc_basic_control #(
    parameter logic [`PBC_IDX_W-1:0] PHY_ADDR = `PBC_DEFAULT_PHY_ADDR
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic mdc,
    input wire logic mdioIn,
    output logic mdioOut,
    output logic mdioOe,
    input wire logic txActive,
    output pbc_pkg::pbc_ctrl_t ctrlOut,
    output logic collisionOut,
    output logic softResetPulse,
    output logic autonegRestartPulse
);
    import pbc_pkg::*;

    // ============================================================
    // Helpers
    function automatic logic [`PBC_DATA_W-1:0] readValue(
        input logic [`PBC_IDX_W-1:0] idx,
        input logic [`PBC_DATA_W-1:0] regVal
    );
        logic [`PBC_DATA_W-1:0] v;
        v = '0;
        // Other indices of the space belong to other blocks and read zero here
        if (idx == `PBC_IDX_BASIC_CONTROL) begin
            v = regVal & ~`PBC_SC_MASK;
        end
        return v;
    endfunction

    function automatic pbc_speed_t speedOf(input logic [`PBC_DATA_W-1:0] regVal);
        return pbc_speed_t'({regVal[`PBC_BIT_SPEED_HI], regVal[`PBC_BIT_SPEED_LO]});
    endfunction

    // ============================================================
    // Pin synchronisers
    logic [`PBC_SYNC_W-1:0] pinLevel;
    logic [`PBC_SYNC_W-1:0] pinRise;
    logic mdcRise;
    logic mdioBit;

    pbc_pin_sync u_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .pinIn({mdioIn, mdc}),
        .pinLevel(pinLevel),
        .pinRise(pinRise)
    );

    assign mdcRise = pinRise[0];
    assign mdioBit = pinLevel[1];

    // ============================================================
    // State
    pbc_core_t cr_q;
    pbc_core_t cr_d;

    always_comb begin
        cr_d = cr_q;
        cr_d.softResetPulse = 1'b0;
        cr_d.autonegRestartBit = 1'b0;
        // Collision follows transmit only in test mode
        cr_d.collision = cr_q.ctrlReg[`PBC_BIT_COL_TEST] & txActive;
        if (mdcRise) begin
            case (cr_q.state)
                PBC_IDLE: begin
                    // Preamble may be suppressed: any one followed by zero starts
                    cr_d.mdioOe = 1'b0;
                    if (mdioBit) begin
                        cr_d.cnt = 5'h01;
                    end else if (cr_q.cnt != '0) begin
                        cr_d.state = PBC_START;
                        cr_d.cnt = '0;
                    end
                end
                PBC_START: begin
                    cr_d.cnt = '0;
                    cr_d.state = mdioBit ? PBC_OPCODE : PBC_IDLE;
                end
                PBC_OPCODE: begin
                    cr_d.opcode = {cr_q.opcode[0], mdioBit};
                    cr_d.cnt = cr_q.cnt + 5'h01;
                    if (cr_q.cnt + 5'h01 == `PBC_OP_BITS) begin
                        cr_d.cnt = '0;
                        if ({cr_q.opcode[0], mdioBit} == `PBC_OP_READ) begin
                            cr_d.isRead = 1'b1;
                            cr_d.state = PBC_ADDR;
                        end else if ({cr_q.opcode[0], mdioBit} == `PBC_OP_WRITE) begin
                            cr_d.isRead = 1'b0;
                            cr_d.state = PBC_ADDR;
                        end else begin
                            cr_d.state = PBC_IDLE;
                        end
                    end
                end
                PBC_ADDR: begin
                    cr_d.shift = {cr_q.shift[`PBC_DATA_W-2:0], mdioBit};
                    cr_d.cnt = cr_q.cnt + 5'h01;
                    if (cr_q.cnt + 5'h01 == `PBC_ADDR_BITS) begin
                        cr_d.addrHit = (cr_d.shift[9:5] == PHY_ADDR);
                        cr_d.regIdx = cr_d.shift[4:0];
                        cr_d.cnt = '0;
                        cr_d.state = PBC_TURN;
                    end
                end
                PBC_TURN: begin
                    if (cr_q.isRead) begin
                        // Drive the second turnaround bit low, then data
                        cr_d.mdioOe = cr_q.addrHit;
                        cr_d.mdioOut = 1'b0;
                        cr_d.shift = readValue(cr_q.regIdx, cr_q.ctrlReg);
                        cr_d.cnt = '0;
                        cr_d.state = PBC_RDATA;
                    end else if (cr_q.cnt == `PBC_TA_LAST) begin
                        cr_d.cnt = '0;
                        cr_d.state = PBC_WDATA;
                    end else begin
                        cr_d.cnt = cr_q.cnt + 5'h01;
                    end
                end
                PBC_RDATA: begin
                    if (cr_q.cnt == `PBC_DATA_BITS) begin
                        cr_d.mdioOe = 1'b0;
                        cr_d.cnt = '0;
                        cr_d.state = PBC_IDLE;
                    end else begin
                        cr_d.mdioOut = cr_q.shift[`PBC_DATA_W-1];
                        cr_d.shift = {cr_q.shift[`PBC_DATA_W-2:0], 1'b0};
                        cr_d.cnt = cr_q.cnt + 5'h01;
                    end
                end
                PBC_WDATA: begin
                    cr_d.shift = {cr_q.shift[`PBC_DATA_W-2:0], mdioBit};
                    cr_d.cnt = cr_q.cnt + 5'h01;
                    if (cr_q.cnt + 5'h01 == `PBC_DATA_BITS) begin
                        cr_d.cnt = '0;
                        cr_d.state = PBC_IDLE;
                        if (cr_q.addrHit && cr_q.regIdx == `PBC_IDX_BASIC_CONTROL) begin
                            if (cr_d.shift[`PBC_BIT_SOFT_RESET]) begin
                                // Reset wins over every other bit of the same write
                                cr_d.ctrlReg = `PBC_BASIC_CONTROL_RST;
                                cr_d.softResetPulse = 1'b1;
                                cr_d.collision = 1'b0;
                            end else begin
                                cr_d.ctrlReg = cr_d.shift & ~`PBC_SC_MASK;
                                cr_d.autonegRestartBit =
                                    cr_d.shift[`PBC_BIT_AUTONEG_RESTART];
                            end
                        end
                    end
                end
                default: begin
                    cr_d.state = PBC_IDLE;
                    cr_d.mdioOe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cr_q <= '0;
            cr_q.state <= PBC_IDLE;
            cr_q.ctrlReg <= `PBC_BASIC_CONTROL_RST;
        end else begin
            cr_q <= cr_d;
        end
    end

    // ============================================================
    // Outputs
    assign mdioOut = cr_q.mdioOut;
    assign mdioOe = cr_q.mdioOe;
    assign softResetPulse = cr_q.softResetPulse;
    assign autonegRestartPulse = cr_q.autonegRestartBit;
    assign collisionOut = cr_q.collision;

    always_comb begin
        ctrlOut.loopbackEnableBit = cr_q.ctrlReg[`PBC_BIT_LOOPBACK];
        ctrlOut.autonegEnable = cr_q.ctrlReg[`PBC_BIT_AUTONEG_EN];
        ctrlOut.powerDown = cr_q.ctrlReg[`PBC_BIT_POWER_DOWN];
        ctrlOut.macSideIsolateBit = cr_q.ctrlReg[`PBC_BIT_ISOLATE];
        ctrlOut.duplexFull = cr_q.ctrlReg[`PBC_BIT_DUPLEX];
        ctrlOut.collisionTestBit = cr_q.ctrlReg[`PBC_BIT_COL_TEST];
        ctrlOut.forcedSpeed = speedOf(cr_q.ctrlReg);
        // Speed and duplex only count while negotiation is off and speed is legal
        ctrlOut.forcedModeValid = ~cr_q.ctrlReg[`PBC_BIT_AUTONEG_EN]
            && speedOf(cr_q.ctrlReg) != PBC_SPD_RSVD;
    end

endmodule

// file: logic/pbc_regs.svh
// Register constants, offsets, field positions and timing values of the basic control block
// ============================================================
// Function
// - Respond to all 32 management register indices; index 0 is basic control.
// - Writing 1 to bit 15 resets every register to default; reads 0.
// - Bit 14 set loops transmit data back, keeping it off the network.
// - Speed pair bit 6 and bit 13: 10, 100, 1000 Mb/s, reserved.
// - Bit 12 set (default) runs auto-negotiation, ignoring speed and duplex bits.
// - Bit 11 set enters general power-down; clear restores normal operation.
// - Bit 10 set isolates the device from the MAC-side interface.
// - Writing 1 to bit 9 restarts auto-negotiation; bit self-clears, reads 0.
// - Bit 8 selects forced duplex, default full, used only without auto-negotiation.
// - Bit 7 set asserts collision whenever the device is transmitting.
// - After reset bit 6 reads 1 and bit 13 reads 0 (1000 Mb/s).
`ifndef PBC_REGS_SVH
`define PBC_REGS_SVH

// ============================================================
// Register map
`define PBC_DATA_W 16
`define PBC_IDX_W 5
`define PBC_CNT_W 5
`define PBC_IDX_BASIC_CONTROL 5'h00
`define PBC_BASIC_CONTROL_RST 16'h1140
`define PBC_SC_MASK 16'h8200

// ============================================================
// Field positions
`define PBC_BIT_SOFT_RESET 15
`define PBC_BIT_LOOPBACK 14
`define PBC_BIT_SPEED_LO 13
`define PBC_BIT_AUTONEG_EN 12
`define PBC_BIT_POWER_DOWN 11
`define PBC_BIT_ISOLATE 10
`define PBC_BIT_AUTONEG_RESTART 9
`define PBC_BIT_DUPLEX 8
`define PBC_BIT_COL_TEST 7
`define PBC_BIT_SPEED_HI 6

// ============================================================
// Management frame fields
`define PBC_OP_READ 2'h2
`define PBC_OP_WRITE 2'h1
`define PBC_ADDR_BITS 5'h0A
`define PBC_DATA_BITS 5'h10
`define PBC_OP_BITS 5'h02
`define PBC_TA_LAST 5'h01
`define PBC_SYNC_W 2
`define PBC_DEFAULT_PHY_ADDR 5'h01

`endif

// file: logic/pbc_pkg.sv
// Types shared by the basic control block
`include "pbc_regs.svh"

package pbc_pkg;

    // ============================================================
    // Enumerations
    typedef enum logic [2:0] {
        PBC_IDLE = 3'b000,
        PBC_START = 3'b001,
        PBC_OPCODE = 3'b010,
        PBC_ADDR = 3'b011,
        PBC_TURN = 3'b100,
        PBC_WDATA = 3'b101,
        PBC_RDATA = 3'b110
    } pbc_state_t;

    typedef enum logic [1:0] {
        PBC_SPD_10 = 2'b00,
        PBC_SPD_100 = 2'b01,
        PBC_SPD_1000 = 2'b10,
        PBC_SPD_RSVD = 2'b11
    } pbc_speed_t;

    // ============================================================
    // Carriers
    typedef struct packed {
        logic loopbackEnableBit;
        logic autonegEnable;
        logic powerDown;
        logic macSideIsolateBit;
        logic duplexFull;
        logic collisionTestBit;
        pbc_speed_t forcedSpeed;
        logic forcedModeValid;
    } pbc_ctrl_t;

    typedef struct packed {
        logic [`PBC_SYNC_W-1:0] s1;
        logic [`PBC_SYNC_W-1:0] s2;
        logic [`PBC_SYNC_W-1:0] s3;
        logic [`PBC_SYNC_W-1:0] stable;
    } pbc_sync_t;

    typedef struct packed {
        pbc_state_t state;
        logic [`PBC_CNT_W-1:0] cnt;
        logic [`PBC_DATA_W-1:0] shift;
        logic [1:0] opcode;
        logic isRead;
        logic addrHit;
        logic [`PBC_IDX_W-1:0] regIdx;
        logic [`PBC_DATA_W-1:0] ctrlReg;
        logic mdioOut;
        logic mdioOe;
        logic softResetPulse;
        logic autonegRestartBit;
        logic collision;
    } pbc_core_t;

endpackage

// file: logic/pbc_pin_sync.sv
// Three-stage synchroniser with agreement filter for the management pins
`timescale 1ns/1ns
`include "pbc_regs.svh"

module pbc_pin_sync (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [`PBC_SYNC_W-1:0] pinIn,
    output logic [`PBC_SYNC_W-1:0] pinLevel,
    output logic [`PBC_SYNC_W-1:0] pinRise
);
    import pbc_pkg::*;

    pbc_sync_t st_q;
    pbc_sync_t st_d;
    logic [`PBC_SYNC_W-1:0] agree;

    // ============================================================
    // Filter: a change counts only once stages two and three agree
    always_comb begin
        st_d = st_q;
        st_d.s1 = pinIn;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        agree = ~(st_q.s2 ^ st_q.s3);
        st_d.stable = (agree & st_q.s3) | (~agree & st_q.stable);
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign pinLevel = st_q.stable;
    assign pinRise = ~(st_q.s2 ^ st_q.s3) & st_q.s3 & ~st_q.stable;

endmodule

// file: dv/pbc_basic_control_asserts.sv
// Port-level checks on the basic control register block
`timescale 1ns/1ns
module pbc_basic_control_asserts (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic mdc,
    input wire logic mdioIn,
    input wire logic mdioOut,
    input wire logic mdioOe,
    input wire logic txActive,
    input wire pbc_pkg::pbc_ctrl_t ctrlOut,
    input wire logic collisionOut,
    input wire logic softResetPulse,
    input wire logic autonegRestartPulse
);
    import pbc_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // ============================================================
    // Default image: autoneg on, full duplex, 1000 forced speed
    wire isDef = (ctrlOut == 9'h094);
    col_follows_tx_a: assert property (
        collisionOut == ($past(ctrlOut.collisionTestBit && txActive) && !softResetPulse))
        else $error("collision output does not follow transmit");
    forced_valid_a: assert property (
        ctrlOut.forcedModeValid == (!ctrlOut.autonegEnable && ctrlOut.forcedSpeed != PBC_SPD_RSVD))
        else $error("forced mode valid wrong");
    sr_single_a: assert property (softResetPulse |=> !softResetPulse)
        else $error("soft reset pulse longer than one cycle");
    sr_default_a: assert property (softResetPulse |=> isDef [*4])
        else $error("soft reset did not restore defaults");
    an_single_a: assert property (autonegRestartPulse |=> !autonegRestartPulse)
        else $error("restart pulse longer than one cycle");
    pulse_excl_a: assert property (!(softResetPulse && autonegRestartPulse))
        else $error("restart pulse together with soft reset");
    rst_default_a: assert property ($rose(rst_n) |-> isDef)
        else $error("control outputs not at default after reset");
    read_hold_a: assert property (mdioOe |=> $stable(ctrlOut))
        else $error("control changed during a read");
    ta_zero_a: assert property ($rose(mdioOe) |-> mdc && !mdioOut)
        else $error("turnaround drive not zero after clock rise");
endmodule

// file: dv/pbc_mgmt_model.sv
// Station management controller model sending management frames
`timescale 1ns/1ns
module pbc_mgmt_model (
    input wire logic core_clk,
    input wire logic mdioOut,
    input wire logic mdioOe,
    output logic mdc,
    output logic mdioIn
);
    logic drv = 1'b0;
    logic val = 1'b1;
    // ============================================================
    // Line is pulled up when nobody drives it
    assign mdioIn = mdioOe ? mdioOut : (drv ? val : 1'b1);
    initial begin
        mdc = 1'b0;
    end
    // Clock stands low between frames; the trailing rise doubles as the next preamble
    task automatic xfer(input logic rd, input logic [4:0] pa, input logic [4:0] ra,
                        input logic [15:0] wd, output logic [16:0] got);
        logic [32:0] v;
        v = {3'h5, rd, !rd, pa, ra, 2'h2, wd};
        got = 17'h0;
        for (int i = 32; i >= -1; i--) begin
            @(posedge core_clk);
            mdc <= 1'b0;
            drv <= !(rd && i < 18);
            val <= (i >= 0) ? v[i] : 1'b1;
            repeat (8) @(posedge core_clk);
            // Samples the turnaround zero and the sixteen data bits, one per slot
            if (i >= 0 && i < 17) got = {got[15:0], mdioIn};
            mdc <= 1'b1;
            repeat (7) @(posedge core_clk);
        end
        @(posedge core_clk);
        mdc <= 1'b0;
        drv <= 1'b0;
    endtask
endmodule

// file: dv/test_phy_basic_control.sv
// Self-checking bench for the basic control register block
`timescale 1ns/1ns
`include "pbc_regs.svh"
module test_phy_basic_control;
    import pbc_pkg::*;
    logic core_clk;
    logic rst_n = 1'b0;
    logic txActive = 1'b0;
    logic mdc;
    logic mdioIn;
    logic mdioOut;
    logic mdioOe;
    pbc_ctrl_t ctrlOut;
    logic collisionOut;
    logic softResetPulse;
    logic autonegRestartPulse;
    int mismatches = 0;
    int samples_checked = 0;
    int srSeen = 0;
    int anSeen = 0;
    logic colExp = 1'b0;
    logic [15:0] regM;
    logic [15:0] w;
    logic [16:0] got;
    pbc_basic_control pbc_basic_control_inst (.core_clk, .rst_n, .mdc, .mdioIn, .mdioOut,
        .mdioOe, .txActive, .ctrlOut, .collisionOut, .softResetPulse, .autonegRestartPulse);
    pbc_mgmt_model pbc_mgmt_model_inst (.core_clk, .mdioOut, .mdioOe, .mdc, .mdioIn);
    // ============================================================
    // Clock, random transmit activity, pulse counters
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = !core_clk;
    end
    always @(posedge core_clk) begin
        txActive <= 1'($urandom_range(0, 1));
        if (softResetPulse === 1'b1) srSeen++;
        if (autonegRestartPulse === 1'b1) anSeen++;
        // Soft reset clears the collision flop along with the register
        if (rst_n && softResetPulse !== 1'b1) begin
            check("col", {16'h0000, collisionOut}, {16'h0000, colExp});
        end
        colExp <= ctrlOut.collisionTestBit && txActive;
    end
    // ============================================================
    // Model and helpers
    function automatic logic [16:0] ctrlOf(input logic [15:0] r);
        return {8'h00, r[14], r[12], r[11], r[10], r[8], r[7], r[6], r[13],
            !r[12] && {r[6], r[13]} != 2'h3};
    endfunction
    task automatic check(input string name, input logic [16:0] seen, input logic [16:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] d);
        pbc_mgmt_model_inst.xfer(1'b0, pa, ra, d, got);
    endtask
    task automatic rd(input logic [4:0] pa, input logic [4:0] ra);
        pbc_mgmt_model_inst.xfer(1'b1, pa, ra, 16'h0, got);
    endtask
    task automatic tally_and_finish;
        if (mismatches == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge core_clk);
        mismatches++;
        tally_and_finish();
    end
    // ============================================================
    // Main sequence
    initial begin
        regM = `PBC_BASIC_CONTROL_RST;
        void'($urandom(26657));
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        check("ctrl", {8'h00, ctrlOut}, ctrlOf(regM));
        rd(`PBC_DEFAULT_PHY_ADDR, 5'h00);
        check("reset", got, {1'b0, regM});
        for (int k = 0; k < 8; k++) begin
            w = 16'($urandom);
            w[15] = 1'b0;
            w[9] = 1'b0;
            w[7] = k[0];
            w[14] = w[14] | w[7];
            {w[6], w[13]} = k[1:0];
            w[12] = k[2];
            wr(`PBC_DEFAULT_PHY_ADDR, 5'h00, w);
            regM = w;
            check("ctrl", {8'h00, ctrlOut}, ctrlOf(regM));
            rd(`PBC_DEFAULT_PHY_ADDR, 5'h00);
            check("rdback", got, {1'b0, regM});
        end
        wr(`PBC_DEFAULT_PHY_ADDR, 5'h00, regM | 16'h0200);
        check("anPulse", 17'(anSeen), 17'h1);
        rd(`PBC_DEFAULT_PHY_ADDR, 5'h00);
        check("anClear", got, {1'b0, regM});
        wr(`PBC_DEFAULT_PHY_ADDR, 5'h00, regM);
        check("anNone", 17'(anSeen), 17'h1);
        wr(5'h1E, 5'h00, 16'h0000);
        rd(5'h1E, 5'h00);
        check("noDrive", got, 17'h1FFFF);
        wr(`PBC_DEFAULT_PHY_ADDR, 5'h05, 16'hFFFF);
        rd(`PBC_DEFAULT_PHY_ADDR, 5'h05);
        check("reg5", got, 17'h0);
        rd(`PBC_DEFAULT_PHY_ADDR, 5'h1F);
        check("reg31", got, 17'h0);
        rd(`PBC_DEFAULT_PHY_ADDR, 5'h00);
        check("reg0", got, {1'b0, regM});
        // Soft reset drops the other bits of the same write, restart included
        wr(`PBC_DEFAULT_PHY_ADDR, 5'h00, 16'hC6FF);
        regM = `PBC_BASIC_CONTROL_RST;
        check("srPulse", 17'(srSeen), 17'h1);
        check("anAfterSr", 17'(anSeen), 17'h1);
        check("ctrl", {8'h00, ctrlOut}, ctrlOf(regM));
        rd(`PBC_DEFAULT_PHY_ADDR, 5'h00);
        check("srRead", got, {1'b0, regM});
        tally_and_finish();
    end
endmodule

bind pbc_basic_control pbc_basic_control_asserts pbc_basic_control_asserts_inst (.core_clk,
    .rst_n, .mdc, .mdioIn, .mdioOut, .mdioOe, .txActive, .ctrlOut, .collisionOut,
    .softResetPulse, .autonegRestartPulse);
